// file: oms_pkg.sv
package oms_pkg;
  localparam int unsigned REG_W       = 24;
  localparam int unsigned SP_W        = 6;
  localparam int unsigned RSV_HI      = 23;
  localparam int unsigned RSV_LO      = 21;
  localparam int unsigned SEN_BIT     = 20;
  localparam int unsigned WRP_BIT     = 19;
  localparam int unsigned OVF_BIT     = 18;
  localparam int unsigned UNF_BIT     = 17;
  localparam int unsigned XYS_BIT     = 16;
  localparam int unsigned MODE_HI     = 3;
  localparam int unsigned MODE_LO     = 0;
  localparam int unsigned LOW_HI      = 15;
  localparam int unsigned MODE_W      = 4;
  localparam logic [23:0] RESET_VALUE = 24'h000300;
  localparam logic [23:0] LOW_MASK    = 24'h00FFFF;
  localparam logic [23:0] STACK_MASK  = 24'h1F0000;
  localparam logic [23:0] STACK_WMASK = 24'h110000;
  typedef enum logic [1:0] {
    OMS_OP_MOVE = 2'h0,
    OMS_OP_AND  = 2'h1,
    OMS_OP_OR   = 2'h2
  } oms_op_t;
  typedef enum logic [2:0] {
    OMS_ST_RESET = 3'h1,
    OMS_ST_RUN   = 3'h2,
    OMS_ST_ERR   = 3'h4
  } oms_state_t;
endpackage

// file: oms_edge.sv
`timescale 1ns/100ps
// one-cycle pulse on the edge where a flag rises; fed the flag's next value
module oms_edge (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic flag,
  output logic      pulse_q
);
  logic prev_q;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prev_q  <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      prev_q  <= flag;
      pulse_q <= flag & ~prev_q;
    end
  end
endmodule

// file: oms_mode_reg.sv
`timescale 1ns/100ps
// What this block does
// - 24-bit read/write register, three bytes
// - low bytes mode, high byte stack control
// - low bytes change only on reset, the first-clock pin load or explicit write
// - stack byte via loop/call/return and move
// - first clock after reset loads mode bits 3..0 from pins
// - bits 23..21 reset and read zero
// - bit 20 enables stack extension, reset clear
// - wrap flag set when spill begins
// - flags sticky until reset or move write
// - overflow on push at size when enabled
// - overflow rise raises level 3 error
// - underflow on pull at zero when enabled
// - underflow rise raises level 3 error
// - pointer underflow bit counts in extended mode
// - bit 16 selects X or Y space
module oms_mode_reg #(
  parameter int unsigned SP_W = oms_pkg::SP_W
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  input  wire logic [3:0]              mode_pins,
  input  wire logic                    wr_en,
  input  wire oms_pkg::oms_op_t        wr_op,
  input  wire logic [23:0]             wr_data,
  input  wire logic                    stack_wr_en,
  input  wire logic [7:0]              stack_wr_data,
  input  wire logic                    spill_start,
  input  wire logic                    push_req,
  input  wire logic                    pull_req,
  input  wire logic [SP_W-1:0]         stack_pointer,
  input  wire logic [SP_W-1:0]         stack_size_reg,
  output logic [23:0]                  rd_data_q,
  output logic                         stack_ext_enable_q,
  output logic                         stack_space_select_q,
  output logic                         uf_as_count_q,
  output logic                         stack_error_q
);
  logic [15:0] low_q;
  logic [15:0] low_d;
  logic        en_q;
  logic        xys_q;
  logic        wrap_q;
  logic        ovf_q;
  logic        unf_q;
  logic        move_wr;
  logic        ovf_set;
  logic        unf_set;
  logic        wrap_d;
  logic        ovf_d;
  logic        unf_d;
  logic        ovf_pulse;
  logic        unf_pulse;
  logic        boot_q;
  logic        err_q;
  logic [23:0] cur;
  oms_pkg::oms_state_t st_q;

  // stack byte starts at the space select bit
  function automatic int unsigned byte_pos(input int unsigned pos);
    return pos - oms_pkg::XYS_BIT;
  endfunction

  // hardware set beats a clearing move in the same cycle
  function automatic logic flag_next(input logic set, input logic cur_v, input logic clr);
    return set | (cur_v & ~clr);
  endfunction

  assign move_wr = wr_en && (wr_op == oms_pkg::OMS_OP_MOVE);
  assign ovf_set = push_req && en_q && (stack_pointer == stack_size_reg);
  assign unf_set = pull_req && en_q && (stack_pointer == '0);
  // next flag values feed the edge pulses, so no extra cycle of lag
  assign wrap_d  = flag_next(spill_start, wrap_q, move_wr);
  assign ovf_d   = flag_next(ovf_set, ovf_q, move_wr);
  assign unf_d   = flag_next(unf_set, unf_q, move_wr);

  always_comb begin
    cur = '0;
    cur[oms_pkg::LOW_HI:0] = low_q;
    cur[oms_pkg::SEN_BIT]  = en_q;
    cur[oms_pkg::WRP_BIT]  = wrap_q;
    cur[oms_pkg::OVF_BIT]  = ovf_q;
    cur[oms_pkg::UNF_BIT]  = unf_q;
    cur[oms_pkg::XYS_BIT]  = xys_q;
  end

  always_comb begin
    low_d = low_q;
    if (wr_en) begin
      case (wr_op)
        oms_pkg::OMS_OP_AND: low_d = low_q & wr_data[oms_pkg::LOW_HI:0];
        oms_pkg::OMS_OP_OR:  low_d = low_q | wr_data[oms_pkg::LOW_HI:0];
        default:             low_d = wr_data[oms_pkg::LOW_HI:0];
      endcase
    end
  end

  // pins caught on the first clock after release, never inside the reset branch
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      boot_q <= 1'b1;
      low_q  <= oms_pkg::RESET_VALUE[oms_pkg::LOW_HI:0];
    end else begin
      boot_q <= 1'b0;
      if (boot_q) begin
        low_q <= low_d;
        low_q[oms_pkg::MODE_HI:oms_pkg::MODE_LO] <= mode_pins;
      end else begin
        low_q <= low_d;
      end
    end
  end

  // stack byte; and/or immediates leave it alone, only moves and implicit accesses reach it
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      en_q  <= 1'b0;
      xys_q <= 1'b0;
    end else if (move_wr) begin
      en_q  <= wr_data[oms_pkg::SEN_BIT];
      xys_q <= wr_data[oms_pkg::XYS_BIT];
    end else if (stack_wr_en) begin
      en_q  <= stack_wr_data[byte_pos(oms_pkg::SEN_BIT)];
      xys_q <= stack_wr_data[byte_pos(oms_pkg::XYS_BIT)];
    end
  end

  // set wins over a clearing move in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wrap_q <= 1'b0;
      ovf_q  <= 1'b0;
      unf_q  <= 1'b0;
    end else begin
      wrap_q <= wrap_d;
      ovf_q  <= ovf_d;
      unf_q  <= unf_d;
    end
  end

  oms_edge u_ovf_edge (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .flag    (ovf_d),
    .pulse_q (ovf_pulse)
  );
  oms_edge u_unf_edge (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .flag    (unf_d),
    .pulse_q (unf_pulse)
  );

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_q <= oms_pkg::OMS_ST_RESET;
    end else begin
      case (st_q)
        oms_pkg::OMS_ST_RESET: st_q <= oms_pkg::OMS_ST_RUN;
        oms_pkg::OMS_ST_RUN:   st_q <= (ovf_q | unf_q) ? oms_pkg::OMS_ST_ERR : st_q;
        oms_pkg::OMS_ST_ERR:   st_q <= (ovf_q | unf_q) ? st_q : oms_pkg::OMS_ST_RUN;
        default:               st_q <= oms_pkg::OMS_ST_RESET;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      err_q                <= 1'b0;
      rd_data_q            <= '0;
      stack_ext_enable_q   <= 1'b0;
      stack_space_select_q <= 1'b0;
      uf_as_count_q        <= 1'b0;
    end else begin
      err_q                <= ovf_pulse | unf_pulse;
      rd_data_q            <= cur;
      stack_ext_enable_q   <= en_q;
      stack_space_select_q <= xys_q;
      uf_as_count_q        <= en_q;
    end
  end
  assign stack_error_q = err_q;

  sequence ovf_cause_s;
    push_req && en_q && (stack_pointer == stack_size_reg);
  endsequence
  sequence ovf_rise_s;
    $rose(ovf_q);
  endsequence

  ovf_flag_a: assert property (@(posedge mclk) disable iff (!rst_b)
    ovf_cause_s |=> ovf_q) else $error("overflow flag not set");
  unf_flag_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (pull_req && en_q && stack_pointer == '0) |=> unf_q) else $error("underflow flag not set");
  wrap_flag_a: assert property (@(posedge mclk) disable iff (!rst_b)
    spill_start |=> wrap_q) else $error("wrap flag not set");
  flag_sticky_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (ovf_q && !move_wr) |=> ovf_q) else $error("overflow flag lost");
  ovf_error_a: assert property (@(posedge mclk) disable iff (!rst_b)
    ovf_rise_s |=> stack_error_q) else $error("no error for overflow");
  unf_error_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(unf_q) |=> stack_error_q) else $error("no error for underflow");
  error_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
    stack_error_q |=> !stack_error_q) else $error("error not one cycle");
  rsv_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_data_q[oms_pkg::RSV_HI:oms_pkg::RSV_LO] == '0) else $error("reserved bits set");
  low_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (!wr_en && !boot_q) |=> $stable(low_q)) else $error("low bytes changed");
  mode_load_a: assert property (@(posedge mclk) disable iff (!rst_b)
    boot_q |=> low_q[oms_pkg::MODE_HI:oms_pkg::MODE_LO] == $past(mode_pins))
    else $error("mode pins not loaded");
  space_sel_a: assert property (@(posedge mclk) disable iff (!rst_b)
    move_wr |=> ##1 stack_space_select_q == $past(wr_data[oms_pkg::XYS_BIT], 2))
    else $error("space select wrong");
  stack_byte_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (stack_wr_en && !move_wr) |=> en_q == $past(stack_wr_data[byte_pos(oms_pkg::SEN_BIT)]))
    else $error("stack byte enable not taken");
  space_byte_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (stack_wr_en && !move_wr) |=> xys_q == $past(stack_wr_data[byte_pos(oms_pkg::XYS_BIT)]))
    else $error("stack byte select not taken");
  flag_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (move_wr && !ovf_set) |=> !ovf_q) else $error("overflow flag not cleared");
  uf_count_a: assert property (@(posedge mclk) disable iff (!rst_b)
    en_q |=> uf_as_count_q) else $error("pointer bit not counting");
  err_state_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (ovf_q || unf_q) |=> st_q == oms_pkg::OMS_ST_ERR) else $error("error state not held");
endmodule

// file: oms_stack_model.sv
`timescale 1ns/100ps
// behavioural stack pointer; tiny size so both boundaries come up often
module oms_stack_model #(
  parameter int unsigned SP_W = 6
) (
  input  wire logic [7:0] rnd,
  input  wire logic       mclk,
  output logic            push_req,
  output logic            pull_req,
  output logic            spill_start,
  output logic [SP_W-1:0] stack_pointer,
  output logic [SP_W-1:0] stack_size_reg
);
  initial begin
    {push_req, pull_req, spill_start} = 3'h0;
    stack_pointer = '0;
    stack_size_reg = SP_W'(3);
  end
  always @(posedge mclk) begin
    push_req <= #1 rnd[1:0] == 2'h1;
    pull_req <= #1 rnd[1:0] == 2'h2;
    spill_start <= #1 rnd[7:5] == 3'h0;
    if (push_req && stack_pointer != stack_size_reg) stack_pointer <= #1 stack_pointer + 1'h1;
    if (pull_req && stack_pointer != '0) stack_pointer <= #1 stack_pointer - 1'h1;
  end
endmodule

// file: oms_mode_reg_bench.sv
`timescale 1ns/100ps
module oms_mode_reg_bench;
  localparam int unsigned N = 700;
  logic             mclk          = 1'h0;
  logic             rst_b         = 1'h0;
  logic [3:0]       mode_pins     = 4'hA;
  logic             wr_en         = 1'h0;
  oms_pkg::oms_op_t wr_op         = oms_pkg::OMS_OP_MOVE;
  logic [23:0]      wr_data       = 24'h0;
  logic             stack_wr_en   = 1'h0;
  logic [7:0]       stack_wr_data = 8'h0;
  logic [7:0]       rnd           = 8'h0;
  logic             push_req, pull_req, spill_start, stack_ext_enable_q;
  logic             stack_space_select_q, uf_as_count_q, stack_error_q;
  logic [5:0]       stack_pointer, stack_size_reg;
  logic [23:0]      rd_data_q;
  int               fails         = 0;
  int               checks_done   = 0;
  int               m, n, exp_rd;
  bit               exp_err, rise, act;
  always #2.5 mclk = ~mclk;
  oms_mode_reg dut (.mclk, .rst_b, .mode_pins, .wr_en, .wr_op, .wr_data, .stack_wr_en,
    .stack_wr_data, .spill_start, .push_req, .pull_req, .stack_pointer, .stack_size_reg,
    .rd_data_q, .stack_ext_enable_q, .stack_space_select_q, .uf_as_count_q, .stack_error_q);
  oms_stack_model ptn (.mclk, .rnd, .push_req, .pull_req, .spill_start, .stack_pointer,
    .stack_size_reg);
  // reference model: state moves at the edge, outputs show it one edge later
  always @(posedge mclk) begin
    if (!rst_b) begin
      exp_rd = 0;
      exp_err = 1'b0;
      rise = 1'b0;
      act = 1'b0;
      m = 32'h300;
    end else begin
      exp_rd = m;
      exp_err = rise;
      n = m;
      if (wr_en && wr_op == oms_pkg::OMS_OP_MOVE) n = wr_data & 24'h11FFFF;
      else begin
        if (wr_en && wr_op == oms_pkg::OMS_OP_AND) n = m & (24'hFF0000 | wr_data[15:0]);
        if (wr_en && wr_op == oms_pkg::OMS_OP_OR) n = m | wr_data[15:0];
        if (stack_wr_en) n = (n & ~32'h110000) | (int'(stack_wr_data[4]) << 20)
          | (int'(stack_wr_data[0]) << 16);
      end
      if (spill_start) n |= 32'h80000;
      if (push_req && m[20] && stack_pointer == stack_size_reg) n |= 32'h40000;
      if (pull_req && m[20] && stack_pointer == 6'h0) n |= 32'h20000;
      if (!act) n = (n & ~32'hF) | mode_pins;
      rise = ((n & ~m) & 32'h60000) != 0;
      m = n;
      act = 1'b1;
    end
  end
  task automatic chk_reg(string nm, logic [23:0] e, logic [23:0] s);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk_bit(string nm, logic e, logic s);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %b seen %b", nm, e, s);
    end
  endtask
  always @(negedge mclk) begin
    chk_reg("rd_data", 24'(exp_rd), rd_data_q);
    chk_bit("enable", exp_rd[20], stack_ext_enable_q);
    chk_bit("space", exp_rd[16], stack_space_select_q);
    chk_bit("uf_count", exp_rd[20], uf_as_count_q);
    chk_bit("error", exp_err, stack_error_q);
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(6546));
    repeat (12) @(posedge mclk);
    #1 rst_b = 1'h1;
    for (int i = 0; i < N; i++) begin
      @(posedge mclk);
      #1;
      rnd = 8'($urandom);
      wr_en = ($urandom % 4) == 0;
      wr_op = oms_pkg::oms_op_t'($urandom % 3);
      // moves carry random flag and reserved bits; a move may only clear flags
      wr_data = 24'($urandom);
      stack_wr_en = ($urandom % 4) == 0;
      stack_wr_data = 8'($urandom);
      if (i == N / 2) begin
        rst_b = 1'h0;
        mode_pins = 4'h5;
      end
      if (i == N / 2 + 3) rst_b = 1'h1;
    end
    end_of_test();
  end
  initial begin
    #(5 * (N + 60));
    fails++;
    end_of_test();
  end
endmodule
